// *** core/emtc_pkg.sv ***
/*
 Types of the encoder marker and turns counter block.
 Assumes the register header is compiled alongside.
*/
package emtc_pkg;

   // Encoder type selection
   typedef enum logic [3:0] {
      EMTC_QUADRATURE_INCREMENTAL           = 4'b0000,
      EMTC_FREQ_DIRECTION_INCREMENTAL       = 4'b0001,
      EMTC_FORWARD_REVERSE_INCREMENTAL      = 4'b0010,
      EMTC_QUADRATURE_WITH_COMMUTATION      = 4'b0011,
      EMTC_FREQ_DIRECTION_WITH_COMMUTATION  = 4'b0100,
      EMTC_FORWARD_REVERSE_WITH_COMMUTATION = 4'b0101,
      EMTC_SINE_COSINE_PLAIN                = 4'b0110,
      EMTC_SINE_COSINE_WITH_COMMS           = 4'b0111
   } emtc_enc_type_e;

   // Movement step from the counting front end
   typedef enum logic [1:0] {
      EMTC_STEP_NONE = 2'b00,
      EMTC_STEP_UP   = 2'b01,
      EMTC_STEP_DOWN = 2'b10,
      EMTC_STEP_RSV  = 2'b11
   } emtc_step_e;

   typedef logic [47:0] emtc_pos_t;

endpackage

// *** core/emtc_regs.svh ***
/*
 Register offsets, field positions, reset values and limits of the
 encoder marker and turns counter block. Assumes a 32-bit APB slave with
 byte addresses and one register per aligned word.
*/
`ifndef EMTC_REGS_SVH
`define EMTC_REGS_SVH

// Byte offsets
`define EMTC_OFF_CTRL        12'h000
`define EMTC_OFF_TURNS       12'h004
`define EMTC_OFF_STATUS      12'h008
`define EMTC_OFF_MASK        12'h00C
`define EMTC_OFF_POS_LO      12'h010
`define EMTC_OFF_POS_HI      12'h014
`define EMTC_OFF_RATIO       12'h018
`define EMTC_OFF_AUTOCFG     12'h01C

// Control register fields
`define EMTC_CTRL_INHIBIT    0
`define EMTC_CTRL_MODE       1
`define EMTC_CTRL_LINEAR     2
`define EMTC_CTRL_TYPE_LO    4
`define EMTC_CTRL_TYPE_HI    7
`define EMTC_CTRL_POLES_LO   8
`define EMTC_CTRL_POLES_HI   15

// Status and mask fields
`define EMTC_ST_MARKER       0
`define EMTC_ST_WRAP         1

// Reset values
`define EMTC_RST_TURNS       8'h10
`define EMTC_RST_POLES       8'h06
`define EMTC_RST_CTRL        32'h0000_0600

// Limits
`define EMTC_MAX_TURNS_BITS  5'h10
`define EMTC_VISIBLE_MAX     8'hFF

`endif

// *** core/emtc_turns_counter.sv ***
/*
 Encoder position accumulator with marker handling, turns-bit masking,
 linear ratio override, APB register slave and a level interrupt.
 Assumes a counting front end that delivers one-cycle position steps of
 pos_step_size units of 1/2^32 turn, and a marker pin from the encoder.
*/
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

`include "emtc_regs.svh"

// Operation
// - Marker resets position and sets flag; inhibit bit set means flag only
// - Hardware sets marker flag each marker; only software write clears it
// - Marker mode zero clears in-revolution and fine position, keeps revolutions
// - Marker mode one clears the whole 48-bit position
// - Marker acts only for the six incremental encoder types
// - Incremental or plain sine-cosine with zero turns bits holds revolutions at zero
// - Turns bits n lets revolutions reach 2^n-1 then wrap to zero
// - Turns bits above 16 treated as 16, wrapping after 65535
// - Rotary comms encoders use turns bits as multi-turn count and mask
// - Linear comms encoders apply no mask; full 16-bit revolutions
// - Auto-config ratio 256..65535 kept internally; visible setting shows 255
// - Auto-config enabled and saved runs at power-up and each initialization; here the power-up run ignores enable and saved
// - Large internal ratio ignores visible writes; cleared by power-up or small ratio
// - Linear revolution spans the configured motor poles; the poles field is not used here, the front end must scale the steps
// - Position kept as 48 bits: revolutions, position, fine position
// - Revolutions roll over under the turns-bit mask at each boundary
module emtc_turns_counter #(
   parameter int POS_W = 48
) (
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Encoder side
   input  wire logic                     marker_in,
   input  wire emtc_pkg::emtc_step_e     pos_step,
   input  wire logic [31:0]              pos_step_size,
   input  wire logic                     drive_enabled,
   // Auto-configuration result
   input  wire logic                     encoder_init,
   input  wire logic                     autocfg_valid,
   input  wire logic [15:0]              autocfg_ratio,
   // Outputs
   output logic [POS_W-1:0]              position,
   output logic [15:0]                   linear_ratio,
   output logic                          irq
);
   import emtc_pkg::*;

   // Register state
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [7:0]  turns_ff, nxt_turns;
   logic [7:0]  turns_act_ff, nxt_turns_act;
   logic [1:0]  status_ff, nxt_status;
   logic [1:0]  mask_ff, nxt_mask;
   logic        autocfg_en_ff, nxt_autocfg_en;
   logic        autocfg_saved_ff, nxt_autocfg_saved;
   logic [15:0] ratio_ff, nxt_ratio;
   logic        override_ff, nxt_override;
   logic        pend_cfg_ff, nxt_pend_cfg;
   emtc_pos_t   pos_ff, nxt_pos;
   logic [2:0]  mk_sync_ff;
   logic        mk_state_ff, nxt_mk_state;
   logic [31:0] prdata_ff, nxt_prdata;

   // Decoded control
   logic           inhibit, mode_full, linear_sel;
   emtc_enc_type_e enc_type;
   logic           incr_type, marker_evt, wr_acc, rd_acc, addr_ok;
   logic [4:0]     tbits;
   logic [15:0]    rev_mask;
   logic [16:0]    rev_next_raw;
   logic [47:0]    pos_sum;
   logic           wrap_evt;

   assign inhibit    = ctrl_ff[`EMTC_CTRL_INHIBIT];
   assign mode_full  = ctrl_ff[`EMTC_CTRL_MODE];
   assign linear_sel = ctrl_ff[`EMTC_CTRL_LINEAR];
   assign enc_type   = emtc_enc_type_e'(ctrl_ff[`EMTC_CTRL_TYPE_HI:`EMTC_CTRL_TYPE_LO]);
   assign incr_type  = (ctrl_ff[`EMTC_CTRL_TYPE_HI:`EMTC_CTRL_TYPE_LO] <= 4'h5);
   assign wr_acc     = psel & penable & pwrite;
   assign rd_acc     = psel & ~penable & ~pwrite;
   assign pready     = 1'b1;
   assign pslverr    = 1'b0;
   assign prdata     = prdata_ff;
   assign position   = pos_ff;
   assign linear_ratio = ratio_ff;
   assign irq        = |(status_ff & mask_ff);

   // Marker pin synchroniser; the edge is judged on stages two and three
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mk_sync_ff <= 3'h0;
      end else begin
         mk_sync_ff <= {mk_sync_ff[1:0], marker_in};
      end
   end

   // Filtered marker level and its rising edge
   always_comb begin
      nxt_mk_state = mk_state_ff;
      if (mk_sync_ff[1] == mk_sync_ff[2]) begin
         nxt_mk_state = mk_sync_ff[2];
      end
   end
   assign marker_evt = nxt_mk_state & ~mk_state_ff & incr_type;

   // Turns-bit count clamped at 16; zero means counter held except for linear comms encoders
   always_comb begin
      tbits = (turns_act_ff > 8'h10) ? `EMTC_MAX_TURNS_BITS : turns_act_ff[4:0];
      rev_mask = 16'(({1'b0, 16'hFFFF} >> (5'h10 - tbits)));
      if (linear_sel && enc_type == EMTC_SINE_COSINE_WITH_COMMS) begin
         rev_mask = 16'hFFFF;
      end
   end

   // Position accumulator; revolution field wraps under the turns mask
   always_comb begin
      nxt_pos = pos_ff;
      pos_sum = pos_ff;
      wrap_evt = 1'b0;
      rev_next_raw = {1'b0, pos_ff[47:32]};
      case (pos_step)
         EMTC_STEP_UP:   pos_sum = pos_ff + {16'h0000, pos_step_size};
         EMTC_STEP_DOWN: pos_sum = pos_ff - {16'h0000, pos_step_size};
         default:        pos_sum = pos_ff;
      endcase
      rev_next_raw = {1'b0, pos_sum[47:32]};
      if (pos_sum[47:32] != pos_ff[47:32] &&
          (pos_sum[47:32] & rev_mask) == 16'h0000 && rev_mask != 16'h0000) begin
         wrap_evt = ((pos_ff[47:32] & rev_mask) == rev_mask) || (pos_ff[47:32] == 16'h0000);
      end
      // Revolution units follow the pole span for linear types; front end scales steps
      nxt_pos = {rev_next_raw[15:0] & rev_mask, pos_sum[31:0]};
      if (marker_evt && !inhibit) begin
         if (mode_full) begin
            nxt_pos = 48'h0000_0000_0000;
         end else begin
            nxt_pos = {pos_ff[47:32] & rev_mask, 32'h0000_0000};
         end
      end
   end

   // Registers, interrupt status, ratio override and read data
   always_comb begin
      nxt_ctrl          = ctrl_ff;
      nxt_turns         = turns_ff;
      nxt_turns_act     = turns_act_ff;
      nxt_status        = status_ff;
      nxt_mask          = mask_ff;
      nxt_autocfg_en    = autocfg_en_ff;
      nxt_autocfg_saved = autocfg_saved_ff;
      nxt_ratio         = ratio_ff;
      nxt_override      = override_ff;
      nxt_pend_cfg      = pend_cfg_ff;
      nxt_prdata        = prdata_ff;
      addr_ok           = 1'b1;
      if (wr_acc) begin
         case (paddr)
            `EMTC_OFF_CTRL:    nxt_ctrl = pwdata;
            `EMTC_OFF_TURNS: begin
               if (!override_ff) begin
                  nxt_turns = pwdata[7:0];
                  nxt_ratio = {8'h00, pwdata[7:0]};
               end
            end
            `EMTC_OFF_STATUS:  nxt_status = status_ff & ~pwdata[1:0];
            `EMTC_OFF_MASK:    nxt_mask = pwdata[1:0];
            `EMTC_OFF_AUTOCFG: begin
               nxt_autocfg_en    = pwdata[0];
               nxt_autocfg_saved = pwdata[1];
            end
            default:           addr_ok = 1'b0;
         endcase
      end
      // The turns setting applies only while the drive is disabled
      if (!drive_enabled) begin
         nxt_turns_act = nxt_turns;
      end
      // Auto-configuration at power-up and each encoder initialisation
      if (encoder_init && autocfg_en_ff && autocfg_saved_ff) begin
         nxt_pend_cfg = 1'b1;
      end
      if (pend_cfg_ff && autocfg_valid) begin
         nxt_pend_cfg = 1'b0;
         nxt_ratio = autocfg_ratio;
         if (autocfg_ratio > 16'h00FF) begin
            nxt_turns    = `EMTC_VISIBLE_MAX;
            nxt_override = 1'b1;
         end else begin
            nxt_turns    = autocfg_ratio[7:0];
            nxt_override = 1'b0;
         end
      end
      // Hardware set wins over a same-cycle software clear
      if (marker_evt) begin
         nxt_status[`EMTC_ST_MARKER] = 1'b1;
      end
      if (wrap_evt) begin
         nxt_status[`EMTC_ST_WRAP] = 1'b1;
      end
      if (rd_acc) begin
         case (paddr)
            `EMTC_OFF_CTRL:    nxt_prdata = ctrl_ff;
            `EMTC_OFF_TURNS:   nxt_prdata = {24'h00_0000, turns_ff};
            `EMTC_OFF_STATUS:  nxt_prdata = {30'h0000_0000, status_ff};
            `EMTC_OFF_MASK:    nxt_prdata = {30'h0000_0000, mask_ff};
            `EMTC_OFF_POS_LO:  nxt_prdata = pos_ff[31:0];
            `EMTC_OFF_POS_HI:  nxt_prdata = {16'h0000, pos_ff[47:32]};
            `EMTC_OFF_RATIO:   nxt_prdata = {15'h0000, override_ff, ratio_ff};
            `EMTC_OFF_AUTOCFG: nxt_prdata = {30'h0000_0000, autocfg_saved_ff, autocfg_en_ff};
            default:           nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff          <= `EMTC_RST_CTRL;
         turns_ff         <= `EMTC_RST_TURNS;
         turns_act_ff     <= `EMTC_RST_TURNS;
         status_ff        <= 2'h0;
         mask_ff          <= 2'h0;
         autocfg_en_ff    <= 1'b0;
         autocfg_saved_ff <= 1'b0;
         ratio_ff         <= 16'h0010;
         override_ff      <= 1'b0;
         pend_cfg_ff      <= 1'b1; // Power-up run
         pos_ff           <= 48'h0000_0000_0000;
         mk_state_ff      <= 1'b0;
         prdata_ff        <= 32'h0000_0000;
      end else begin
         ctrl_ff          <= nxt_ctrl;
         turns_ff         <= nxt_turns;
         turns_act_ff     <= nxt_turns_act;
         status_ff        <= nxt_status;
         mask_ff          <= nxt_mask;
         autocfg_en_ff    <= nxt_autocfg_en;
         autocfg_saved_ff <= nxt_autocfg_saved;
         ratio_ff         <= nxt_ratio;
         override_ff      <= nxt_override;
         pend_cfg_ff      <= nxt_pend_cfg;
         pos_ff           <= nxt_pos;
         mk_state_ff      <= nxt_mk_state;
         prdata_ff        <= nxt_prdata;
      end
   end

   // Marker event with reset enabled zeroes the low 32 bits next cycle
   marker_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (marker_evt && !inhibit) |=> (pos_ff[31:0] == 32'h0000_0000))
      else $error("marker did not clear position");

   // Inhibited marker only flags; low position keeps its value when no step moves it
   marker_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
      (marker_evt && inhibit && pos_step == EMTC_STEP_NONE)
      |=> (status_ff[0] && pos_ff[31:0] == $past(pos_ff[31:0])))
      else $error("inhibited marker misbehaved");

   // Flag set by every marker and not self-cleared
   flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      (status_ff[0] && !(wr_acc && paddr == `EMTC_OFF_STATUS && pwdata[0])) |=> status_ff[0])
      else $error("marker flag dropped");

   // Mode zero keeps revolutions
   mode_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (marker_evt && !inhibit && !mode_full) |=> pos_ff[47:32] == ($past(pos_ff[47:32]) & $past(rev_mask)))
      else $error("mode zero altered revolutions");

   // Mode one clears all
   mode_full_a: assert property (@(posedge pclk) disable iff (!presetn)
      (marker_evt && !inhibit && mode_full) |=> pos_ff == 48'h0000_0000_0000)
      else $error("full marker reset failed");

   // No marker action on other types; a clear flag stays clear
   type_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!incr_type && !status_ff[0]) |=> !status_ff[0])
      else $error("marker acted on wrong type");

   // Revolutions never exceed the mask
   rev_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 ((pos_ff[47:32] & ~$past(rev_mask)) == 16'h0000))
      else $error("revolution counter beyond mask");

   // Zero turns bits holds counter at zero
   rev_held_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tbits == 5'h00 && !linear_sel) |=> pos_ff[47:32] == 16'h0000)
      else $error("revolution counter not held");

   // Large ratio shows 255 visibly
   ratio_visible_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pend_cfg_ff && autocfg_valid && autocfg_ratio > 16'h00FF)
      |=> (turns_ff == 8'hFF && override_ff && ratio_ff == $past(autocfg_ratio)))
      else $error("ratio override not taken");

   // Override blocks visible writes
   write_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      (override_ff && wr_acc && paddr == `EMTC_OFF_TURNS && !(pend_cfg_ff && autocfg_valid))
      |=> $stable(turns_ff))
      else $error("write passed during override");

   // Marker steps: the synchronised level settles high, then filtered level and flag land
   sequence mk_rise_s;
      incr_type && mk_sync_ff[2:1] == 2'b11 && !mk_state_ff;
   endsequence
   sequence mk_applied_s;
      mk_state_ff && status_ff[0];
   endsequence
   sequence cfg_small_s;
      pend_cfg_ff && autocfg_valid && autocfg_ratio <= 16'h00FF;
   endsequence

   // A settled rising marker level is one event, flag set at the next edge
   marker_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      mk_rise_s |=> mk_applied_s)
      else $error("marker edge not applied");

   // A held marker level gives no second event
   marker_once_a: assert property (@(posedge pclk) disable iff (!presetn)
      marker_evt |=> !marker_evt)
      else $error("marker event repeated");

   // Every marker event sets the flag, whatever the inhibit bit says
   flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      marker_evt |=> status_ff[0])
      else $error("marker flag not set");

   // Settings above 16 behave as 16 turns bits
   turns_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (turns_act_ff > 8'h10) |-> (rev_mask == 16'hFFFF))
      else $error("turns setting not clamped");

   // Mask for n turns bits is 2^n-1 unless the encoder is linear with comms
   turns_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      (turns_act_ff inside {[8'h01:8'h10]} &&
       !(linear_sel && enc_type == EMTC_SINE_COSINE_WITH_COMMS))
      |-> (rev_mask == 16'((17'h0_0001 << turns_act_ff[4:0]) - 17'h0_0001)))
      else $error("turns mask wrong");

   // Rotary comms encoder with five turns bits wraps backwards to 31
   rotary_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!linear_sel && enc_type == EMTC_SINE_COSINE_WITH_COMMS && turns_act_ff == 8'h05 &&
       pos_step == EMTC_STEP_DOWN && pos_ff[47:32] == 16'h0000 && pos_ff[31:0] < pos_step_size)
      |=> (pos_ff[47:32] == 16'h001F))
      else $error("rotary comms mask wrong");

   // Linear comms encoder wraps backwards to the full 16-bit count
   linear_full_a: assert property (@(posedge pclk) disable iff (!presetn)
      (linear_sel && enc_type == EMTC_SINE_COSINE_WITH_COMMS &&
       pos_step == EMTC_STEP_DOWN && pos_ff[47:32] == 16'h0000 && pos_ff[31:0] < pos_step_size)
      |=> (pos_ff[47:32] == 16'hFFFF))
      else $error("linear revolutions masked");

   // Initialisation with auto-config enabled and saved arms a run
   autocfg_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
      (encoder_init && autocfg_en_ff && autocfg_saved_ff && !autocfg_valid) |=> pend_cfg_ff)
      else $error("auto-config not armed");

   // A small auto-config ratio drops the override and shows the ratio
   override_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_small_s |=> (!override_ff && turns_ff == $past(autocfg_ratio[7:0])))
      else $error("override not cleared");

endmodule

`default_nettype wire

// *** tb/emtc_encoder_model.sv ***
/*
 Encoder model: marker pin and counting front-end steps.
 Assumes its tasks are called just after a rising pclk edge.
*/
`timescale 1ns/10ps
`default_nettype none
module emtc_encoder_model (
   // Clock
   input  wire logic            pclk,
   // Encoder side
   output logic                 marker_in,
   output emtc_pkg::emtc_step_e pos_step,
   output logic [31:0]          pos_step_size
);
   import emtc_pkg::*;
   // Idle levels at time zero
   initial begin
      marker_in = 1'b0;
      pos_step = EMTC_STEP_NONE;
      pos_step_size = 32'h0000_0000;
   end
   // One-cycle steps; size scrambled between them so stale data is useless
   task automatic step(input int n, input emtc_step_e d, input logic [31:0] s);
      repeat (n) begin
         @(posedge pclk);
         pos_step <= d;
         pos_step_size <= s;
         @(posedge pclk);
         pos_step <= EMTC_STEP_NONE;
         pos_step_size <= ~s;
      end
      repeat (3) @(posedge pclk);
   endtask
   // Marker pulse, long enough for the synchroniser
   task automatic mark();
      @(posedge pclk);
      marker_in <= 1'b1;
      repeat (5) @(posedge pclk);
      marker_in <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// *** tb/test_encoder_marker_turns_counter.sv ***
/*
 Self-checking bench: reads queue their expectation, a monitor compares.
 Assumes a zero-wait APB slave and the encoder model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "emtc_regs.svh"
module test_encoder_marker_turns_counter;
   import emtc_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, irq, marker_in;
   logic        drive_enabled = 1'b0, encoder_init = 1'b0, autocfg_valid = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, pos_step_size, f;
   logic [15:0] autocfg_ratio = 16'h0000, linear_ratio;
   logic [47:0] position, exp_pos;
   emtc_step_e  pos_step;
   logic [31:0] q_exp[$], q_msk[$];
   int          n_errors = 0, n_compared = 0;
   logic [7:0]  nt[5] = '{8'd0, 8'd1, 8'd5, 8'd20, 8'd16};
   logic [31:0] mk_ctrl[4] = '{32'h0000_0601, 32'h0000_0600, 32'h0000_0660, 32'h0000_0602};
   localparam logic [31:0] HALF = 32'h8000_0000;

   always #25 pclk = ~pclk;

   emtc_turns_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .marker_in(marker_in), .pos_step(pos_step),
      .pos_step_size(pos_step_size), .drive_enabled(drive_enabled),
      .encoder_init(encoder_init), .autocfg_valid(autocfg_valid),
      .autocfg_ratio(autocfg_ratio), .position(position), .linear_ratio(linear_ratio),
      .irq(irq));
   emtc_encoder_model enc_u (.pclk(pclk), .marker_in(marker_in), .pos_step(pos_step),
      .pos_step_size(pos_step_size));

   task automatic report_and_stop();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] s,
                      input logic [31:0] m);
      n_compared++;
      if ((s & m) !== (e & m)) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", w, e & m, s & m);
      end
   endtask
   task automatic chk_irq(input logic e);
      cmp("irq", {31'h0, e}, {31'h0, irq}, 32'h0000_0001);
   endtask
   // Setup, access until pready, then one idle edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         n_errors++;
         report_and_stop();
      end
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      q_exp.push_back(e);
      q_msk.push_back(m);
      apb(a, 1'b0, $urandom());
   endtask
   task automatic cfg(input logic [15:0] r);
      @(posedge pclk);
      encoder_init <= 1'b1;
      @(posedge pclk);
      encoder_init <= 1'b0;
      autocfg_valid <= 1'b1;
      autocfg_ratio <= r;
      @(posedge pclk);
      autocfg_valid <= 1'b0;
      autocfg_ratio <= ~r;
      repeat (2) @(posedge pclk);
   endtask
   function automatic logic [31:0] revs_of(input logic [7:0] n);
      if (n == 8'd0) return 32'h0000_0000;
      if (n > 8'd16) return 32'h0000_FFFF;
      return (32'h0000_0001 << n) - 32'h0000_0001;
   endfunction

   // Read data taken at the completing edge
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (q_exp.size() == 0) begin
            n_errors++;
            $display("BAD read %h expected none seen %h", paddr, prdata);
         end else begin
            cmp($sformatf("read %h", paddr), q_exp.pop_front(), prdata, q_msk.pop_front());
         end
      end
   end

   initial begin
      void'($urandom(32'h6231a0b3));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`EMTC_OFF_CTRL, `EMTC_RST_CTRL, 32'hFFFF_FFFF);
      rd(`EMTC_OFF_TURNS, 32'h0000_0010, 32'hFFFF_FFFF);
      rd(12'h020, 32'h0000_0000, 32'hFFFF_FFFF);
      // One turn back from zero shows the mask, one forward wraps again
      foreach (nt[i]) begin
         wr(`EMTC_OFF_TURNS, {24'h0, nt[i]});
         enc_u.step(2, EMTC_STEP_DOWN, HALF);
         rd(`EMTC_OFF_POS_HI, revs_of(nt[i]), 32'h0000_FFFF);
         enc_u.step(2, EMTC_STEP_UP, HALF);
         rd(`EMTC_OFF_POS_HI, 32'h0000_0000, 32'h0000_FFFF);
      end
      rd(`EMTC_OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
      // Turns setting waits while the drive runs, applies once it stops
      drive_enabled <= 1'b1;
      wr(`EMTC_OFF_TURNS, 32'h0000_0001);
      enc_u.step(2, EMTC_STEP_DOWN, HALF);
      rd(`EMTC_OFF_POS_HI, 32'h0000_FFFF, 32'h0000_FFFF);
      drive_enabled <= 1'b0;
      enc_u.step(2, EMTC_STEP_UP, HALF);
      rd(`EMTC_OFF_POS_HI, 32'h0000_0000, 32'h0000_FFFF);
      // Comms encoder: rotary masks, linear does not
      wr(`EMTC_OFF_TURNS, 32'h0000_0005);
      for (int k = 0; k < 2; k++) begin
         wr(`EMTC_OFF_CTRL, k ? 32'h0000_0674 : 32'h0000_0670);
         enc_u.step(2, EMTC_STEP_DOWN, HALF);
         rd(`EMTC_OFF_POS_HI, k ? 32'h0000_FFFF : 32'h0000_001F, 32'h0000_FFFF);
         enc_u.step(2, EMTC_STEP_UP, HALF);
      end
      // Marker cases: inhibit, partial reset, wrong type, full reset
      wr(`EMTC_OFF_TURNS, 32'h0000_0010);
      wr(`EMTC_OFF_CTRL, 32'h0000_0600);
      wr(`EMTC_OFF_MASK, 32'h0000_0001);
      enc_u.step(6, EMTC_STEP_UP, HALF);
      exp_pos = 48'h0003_0000_0000;
      f = ($urandom() % 32'h3FFF_FFFF) + 32'h0000_0001;
      for (int k = 0; k < 4; k++) begin
         wr(`EMTC_OFF_STATUS, 32'h0000_0003);
         chk_irq(1'b0);
         wr(`EMTC_OFF_CTRL, mk_ctrl[k]);
         enc_u.step(1, EMTC_STEP_UP, f);
         exp_pos = exp_pos + {16'h0, f};
         enc_u.mark();
         if (k == 1) exp_pos[31:0] = 32'h0000_0000;
         if (k == 3) exp_pos = 48'h0;
         rd(`EMTC_OFF_POS_LO, exp_pos[31:0], 32'hFFFF_FFFF);
         rd(`EMTC_OFF_POS_HI, {16'h0, exp_pos[47:32]}, 32'h0000_FFFF);
         cmp("position", exp_pos[31:0], position[31:0], 32'hFFFF_FFFF);
         cmp("pos revs", {16'h0, exp_pos[47:32]}, {16'h0, position[47:32]},
             32'h0000_FFFF);
         rd(`EMTC_OFF_STATUS, {31'h0, k != 2}, 32'h0000_0001);
         chk_irq(k != 2);
      end
      // Auto-configured large ratio overrides the visible setting
      wr(`EMTC_OFF_CTRL, 32'h0000_0674);
      wr(`EMTC_OFF_AUTOCFG, 32'h0000_0003);
      cfg(16'd300);
      rd(`EMTC_OFF_RATIO, 32'h0001_012C, 32'h0001_FFFF);
      cmp("ratio port", 32'h0000_012C, {16'h0, linear_ratio}, 32'h0000_FFFF);
      rd(`EMTC_OFF_TURNS, 32'h0000_00FF, 32'h0000_00FF);
      wr(`EMTC_OFF_TURNS, 32'h0000_0005);
      rd(`EMTC_OFF_TURNS, 32'h0000_00FF, 32'h0000_00FF);
      cfg(16'd100);
      rd(`EMTC_OFF_RATIO, 32'h0000_0064, 32'h0001_FFFF);
      wr(`EMTC_OFF_TURNS, 32'h0000_0007);
      rd(`EMTC_OFF_TURNS, 32'h0000_0007, 32'h0000_00FF);
      report_and_stop();
   end
endmodule
`default_nettype wire
